/* core/pwmgc_pkg.sv */
// pwmgc_pkg: shared constants and types of the pwm generator control slice.
// assumes a 32-bit axi4-lite register bus with byte addresses below 0x20.
package pwmgc_pkg;

    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CONTROL     = 8'h00;
    localparam logic [7:0] OFF_DUTY        = 8'h04;
    localparam logic [7:0] OFF_PHASE       = 8'h08;
    localparam logic [7:0] OFF_MASTER_DUTY = 8'h0C;
    localparam logic [7:0] OFF_PRIMARY_PER = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;
    localparam logic [7:0] OFF_ACTIVE_DUTY = 8'h1C;

    // control register field positions
    localparam int unsigned BIT_CL_PENDING  = 14;
    localparam int unsigned BIT_TRG_PENDING = 13;
    localparam int unsigned BIT_CL_IRQ_EN   = 11;
    localparam int unsigned BIT_TRG_IRQ_EN  = 10;
    localparam int unsigned BIT_INDEP       = 9;
    localparam int unsigned BIT_SHARED      = 8;
    localparam int unsigned BIT_DT_LO       = 6;
    localparam int unsigned BIT_EXT_RST     = 1;
    localparam int unsigned BIT_IMMEDIATE   = 0;

    // status / mask bit positions
    localparam int unsigned ST_CL  = 0;
    localparam int unsigned ST_TRG = 1;

    // reset values
    localparam logic [15:0] RST_DUTY        = 16'h0000;
    localparam logic [15:0] RST_PHASE       = 16'h0000;
    localparam logic [15:0] RST_MASTER_DUTY = 16'h0000;
    localparam logic [15:0] RST_PRIMARY_PER = 16'hFFFF;
    localparam logic [1:0]  RST_IRQ_MASK    = 2'h3;

    // dead-time mode encodings
    localparam logic [1:0] DT_POSITIVE = 2'h0;
    localparam logic [1:0] DT_NEGATIVE = 2'h1;
    localparam logic [1:0] DT_DISABLED = 2'h2;

    // timing
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned DEAD_TIME_NS = 20;
    localparam logic [7:0]  DEAD_CYCLES =
        8'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       clIrqEn;
        logic       trigIrqEn;
        logic       indep;
        logic       sharedDuty;
        logic [1:0] deadTimeMode;
        logic       extResetEn;
        logic       immediate;
    } pwmgc_ctrl_t;

    localparam pwmgc_ctrl_t RST_CTRL = '0;

endpackage : pwmgc_pkg

/* core/pwmgc_timebase.sv */
// pwmgc_timebase: period counter with synchronous clear and boundary pulse.
// assumes period and clear are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module pwmgc_timebase
    import pwmgc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] period,
    input  wire logic        clear,
    output var  logic [15:0] count,
    output var  logic        boundary
);
    logic        wrap;
    logic [16:0] countInc;

    assign countInc = {1'b0, count} + 17'h0_0001;
    // a shrinking period must not strand the counter above it
    assign wrap     = countInc >= {1'b0, period};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count    <= 16'h0000;
            boundary <= 1'b0;
        end else begin
            if (clear || wrap) begin
                count <= 16'h0000;
            end else begin
                count <= countInc[15:0];
            end
            boundary <= clear || wrap;
        end
    end

endmodule : pwmgc_timebase
`default_nettype wire

/* core/pwmgc_deadtime.sv */
// pwmgc_deadtime: complementary output pair with dead-time insertion.
// assumes pwmIn is a registered level, mode stays put over a dead-time gap.
`timescale 1ns/10ps
`default_nettype none
module pwmgc_deadtime
    import pwmgc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pwmIn,
    input  wire logic [1:0] mode,
    output var  logic       outHigh,
    output var  logic       outLow
);
    logic       prevIn_r;
    logic [7:0] gap_r;
    logic [7:0] gap_nxt;

    always_comb begin
        if (prevIn_r != pwmIn) begin
            gap_nxt = DEAD_CYCLES;
        end else if (gap_r != 8'h00) begin
            gap_nxt = gap_r - 8'h01;
        end else begin
            gap_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevIn_r <= 1'b0;
            gap_r    <= 8'h00;
            outHigh  <= 1'b0;
            outLow   <= 1'b0;
        end else begin
            prevIn_r <= pwmIn;
            gap_r    <= gap_nxt;
            if (gap_nxt != 8'h00 && mode == DT_POSITIVE) begin // RQ7
                outHigh <= 1'b0;
                outLow  <= 1'b0;
            end else if (gap_nxt != 8'h00 && mode == DT_NEGATIVE) begin // RQ7
                outHigh <= 1'b1;
                outLow  <= 1'b1;
            end else begin
                // disabled and the reserved code both pass straight through
                outHigh <= pwmIn;
                outLow  <= ~pwmIn;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DT_POS_GAP: assert property ( // RQ7
        (mode == DT_POSITIVE) && $changed(pwmIn) |=> !outHigh && !outLow)
        else $error("positive dead time did not blank both outputs");

    AST_DT_OFF: assert property ( // RQ7
        (mode == DT_DISABLED) |=> outHigh == $past(pwmIn) && outLow != outHigh)
        else $error("disabled dead time did not pass pwm through");

endmodule : pwmgc_deadtime
`default_nettype wire

/* core/pwmgc_top.sv */
// pwmgc_top: control slice of one pwm generator with axi4-lite registers.
// assumes currentLimit and triggerEvent are synchronous to clk; triggerEvent
// is a one-cycle pulse, currentLimit a comparator level.
//
// Overview of operation
// [RQ1] The current-limit enable lets a limit event set its pending bit; cleared it holds it clear.
// [RQ2] With the trigger enable set, every trigger event raises an interrupt request; here irq rises only while mask bit ST_TRG is set.
// [RQ3] With the trigger enable clear, triggers raise nothing and the trigger pending bit is cleared.
// [RQ4] With independent period select set, the counter period comes from the phase register.
// [RQ5] With independent period select clear, the shared primary period times the counter.
// [RQ6] Shared duty select picks the master duty register, otherwise the local duty register.
// [RQ7] Dead-time mode 00 gives positive, 01 negative, 10 no dead time; 11 is reserved.
// [RQ8] External reset enable in independent mode lets current limit clear the counter.
// [RQ9] External reset enable clear keeps the current-limit input off the counter.
// [RQ10] Immediate update makes a new duty value active on the next clock.
// [RQ11] Without immediate update the duty value goes active only at the period boundary.
// [RQ12] The local duty register is 16 bits, read/write, reset to zero.
// [RQ13] Software keeps duty values between 0x0008 and 0xFFEF inclusive.
// [RQ14] Control bits 5 to 2 ignore writes and read as zero.
// [RQ15] A shared 16-bit master duty register feeds any generator selecting it.
// [RQ16] The pwm level is active while the count is below the active duty value.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pwmgc_top
    import pwmgc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              currentLimit,
    input  wire logic              triggerEvent,
    output var  logic              pwmHigh,
    output var  logic              pwmLow,
    output var  logic              irq
);
    pwmgc_ctrl_t        ctrl_r;
    logic [15:0]        duty_r;
    logic [15:0]        phase_r;
    logic [15:0]        masterDuty_r;
    logic [15:0]        primaryPer_r;
    logic [1:0]         status_r;
    logic [1:0]         status_nxt;
    logic [1:0]         mask_r;
    logic [15:0]        activeDuty_r;
    logic [15:0]        activeDuty_nxt;
    logic               pwmRaw_r;
    logic               limitPrev_r;
    logic               irq_r;

    logic               awHeld_r;
    logic               wHeld_r;
    logic [ADDR_W-1:0]  awAddr_r;
    logic [31:0]        wData_r;
    logic [3:0]         wStrb_r;
    logic               writeGo;

    logic [15:0]        periodSel;
    logic [15:0]        dutySel;
    logic               tbClear;
    logic [15:0]        tbCount;
    logic               tbBoundary;
    logic               limitRise;
    logic [1:0]         events;
    logic [1:0]         enables;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) res[7:0] = data[7:0];
        if (strb[1]) res[15:8] = data[15:8];
        return res;
    endfunction : merge16

    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0]        off);
        return addr[ADDR_W-1:2] == off[7:2];
    endfunction : hits

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:2] <= OFF_ACTIVE_DUTY[7:2];
    endfunction : isMapped

    // control image: unimplemented bits read zero, pending bits mirror the status register
    function automatic logic [15:0] ctrlImage(input pwmgc_ctrl_t c,
                                              input logic [1:0]  st);
        logic [15:0] img;
        img = 16'h0000;
        img[BIT_CL_PENDING]  = st[ST_CL];
        img[BIT_TRG_PENDING] = st[ST_TRG];
        img[BIT_CL_IRQ_EN]   = c.clIrqEn;
        img[BIT_TRG_IRQ_EN]  = c.trigIrqEn;
        img[BIT_INDEP]       = c.indep;
        img[BIT_SHARED]      = c.sharedDuty;
        img[BIT_DT_LO+1]     = c.deadTimeMode[1];
        img[BIT_DT_LO]       = c.deadTimeMode[0];
        img[BIT_EXT_RST]     = c.extResetEn;
        img[BIT_IMMEDIATE]   = c.immediate;
        return img;
    endfunction : ctrlImage

    function automatic logic [15:0] readMux(input logic [ADDR_W-1:0] addr);
        logic [15:0] v;
        v = 16'h0000;
        if (hits(addr, OFF_CONTROL))     v = ctrlImage(ctrl_r, status_r); // RQ14
        if (hits(addr, OFF_DUTY))        v = duty_r;
        if (hits(addr, OFF_PHASE))       v = phase_r;
        if (hits(addr, OFF_MASTER_DUTY)) v = masterDuty_r;
        if (hits(addr, OFF_PRIMARY_PER)) v = primaryPer_r;
        if (hits(addr, OFF_IRQ_STATUS))  v = {14'h0000, status_r};
        if (hits(addr, OFF_IRQ_MASK))    v = {14'h0000, mask_r};
        if (hits(addr, OFF_ACTIVE_DUTY)) v = activeDuty_r;
        return v;
    endfunction : readMux

    // write channel: address and data are held separately, then committed
    assign writeGo = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awAddr_r      <= '0;
            wData_r       <= 32'h0000_0000;
            wStrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r      <= 1'b1;
                awAddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (writeGo) begin
                awHeld_r <= 1'b0;
            end else if (!awHeld_r) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r      <= 1'b1;
                wData_r      <= s_axi_wdata;
                wStrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (writeGo) begin
                wHeld_r <= 1'b0;
            end else if (!wHeld_r) begin
                s_axi_wready <= 1'b1;
            end
            if (writeGo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one-cycle latency from address acceptance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {16'h0000, readMux(s_axi_araddr)};
                s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // software-written registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r       <= RST_CTRL;
            duty_r       <= RST_DUTY;
            phase_r      <= RST_PHASE;
            masterDuty_r <= RST_MASTER_DUTY;
            primaryPer_r <= RST_PRIMARY_PER;
            mask_r       <= RST_IRQ_MASK;
        end else if (writeGo) begin
            if (hits(awAddr_r, OFF_CONTROL)) begin
                // bits 5..2 and the pending mirrors are not stored
                if (wStrb_r[1]) begin
                    ctrl_r.clIrqEn    <= wData_r[BIT_CL_IRQ_EN];
                    ctrl_r.trigIrqEn  <= wData_r[BIT_TRG_IRQ_EN];
                    ctrl_r.indep      <= wData_r[BIT_INDEP];
                    ctrl_r.sharedDuty <= wData_r[BIT_SHARED];
                end
                if (wStrb_r[0]) begin
                    ctrl_r.deadTimeMode <= wData_r[BIT_DT_LO+1:BIT_DT_LO];
                    ctrl_r.extResetEn   <= wData_r[BIT_EXT_RST];
                    ctrl_r.immediate    <= wData_r[BIT_IMMEDIATE];
                end
            end
            if (hits(awAddr_r, OFF_DUTY)) begin
                duty_r <= merge16(duty_r, wData_r, wStrb_r); // RQ12
            end
            if (hits(awAddr_r, OFF_PHASE)) begin
                phase_r <= merge16(phase_r, wData_r, wStrb_r);
            end
            if (hits(awAddr_r, OFF_MASTER_DUTY)) begin
                masterDuty_r <= merge16(masterDuty_r, wData_r, wStrb_r); // RQ15
            end
            if (hits(awAddr_r, OFF_PRIMARY_PER)) begin
                primaryPer_r <= merge16(primaryPer_r, wData_r, wStrb_r);
            end
            if (hits(awAddr_r, OFF_IRQ_MASK) && wStrb_r[0]) begin
                mask_r <= wData_r[1:0];
            end
        end
    end

    // pending status: set beats a write-one clear, disable forces clear
    assign limitRise = currentLimit && !limitPrev_r;
    assign events    = {triggerEvent, limitRise};
    assign enables   = {ctrl_r.trigIrqEn, ctrl_r.clIrqEn};

    always_comb begin
        status_nxt = status_r;
        if (writeGo && hits(awAddr_r, OFF_IRQ_STATUS) && wStrb_r[0]) begin
            status_nxt = status_r & ~wData_r[1:0];
        end
        status_nxt = (status_nxt | (events & enables)) & enables; // RQ1 RQ2 RQ3
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r    <= 2'h0;
            limitPrev_r <= 1'b0;
            irq_r       <= 1'b0;
        end else begin
            status_r    <= status_nxt;
            limitPrev_r <= currentLimit;
            irq_r       <= |(status_nxt & mask_r);
        end
    end

    assign irq = irq_r;

    // time base and duty selection
    assign periodSel = ctrl_r.indep ? phase_r : primaryPer_r; // RQ4 RQ5
    assign tbClear   = ctrl_r.extResetEn && ctrl_r.indep && currentLimit; // RQ8 RQ9
    assign dutySel   = ctrl_r.sharedDuty ? masterDuty_r : duty_r; // RQ6

    pwmgc_timebase u_timebase (
        .clk      (clk),
        .rst      (rst),
        .period   (periodSel),
        .clear    (tbClear),
        .count    (tbCount),
        .boundary (tbBoundary)
    );

    always_comb begin
        if (ctrl_r.immediate || tbBoundary) begin // RQ10 RQ11
            activeDuty_nxt = dutySel;
        end else begin
            activeDuty_nxt = activeDuty_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            activeDuty_r <= RST_DUTY;
            pwmRaw_r     <= 1'b0;
        end else begin
            activeDuty_r <= activeDuty_nxt;
            pwmRaw_r     <= tbCount < activeDuty_r; // RQ16
        end
    end

    pwmgc_deadtime u_deadtime (
        .clk     (clk),
        .rst     (rst),
        .pwmIn   (pwmRaw_r),
        .mode    (ctrl_r.deadTimeMode), // RQ7
        .outHigh (pwmHigh),
        .outLow  (pwmLow)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sWriteCommit;
        writeGo ##1 s_axi_bvalid;
    endsequence

    AST_BRESP_AFTER_COMMIT: assert property (
        writeGo |-> sWriteCommit)
        else $error("write response did not follow commit");

    AST_CL_SET: assert property ( // RQ1
        ctrl_r.clIrqEn && currentLimit && !limitPrev_r |=> status_r[ST_CL])
        else $error("current-limit event not latched");

    AST_CL_CLEAR: assert property ( // RQ1
        !ctrl_r.clIrqEn |=> !status_r[ST_CL])
        else $error("current-limit pending not held clear");

    AST_TRG_SET: assert property ( // RQ2
        ctrl_r.trigIrqEn && triggerEvent |=> status_r[ST_TRG] ##1 irq || !mask_r[ST_TRG]
            || !ctrl_r.trigIrqEn || !status_r[ST_TRG])
        else $error("trigger event did not raise interrupt");

    AST_TRG_CLEAR: assert property ( // RQ3
        !ctrl_r.trigIrqEn |=> !status_r[ST_TRG])
        else $error("trigger pending not forced clear");

    AST_INDEP_WRAP: assert property ( // RQ4
        ctrl_r.indep && !tbClear && ({1'b0, tbCount} + 17'h0_0001 == {1'b0, phase_r})
            |=> tbCount == 16'h0000 && tbBoundary)
        else $error("independent period did not wrap at phase value");

    AST_PRIMARY_WRAP: assert property ( // RQ5
        !ctrl_r.indep && ({1'b0, tbCount} + 17'h0_0001 == {1'b0, primaryPer_r})
            |=> tbCount == 16'h0000)
        else $error("primary period did not wrap");

    AST_EXT_RESET: assert property ( // RQ8
        ctrl_r.extResetEn && ctrl_r.indep && currentLimit |=> tbCount == 16'h0000)
        else $error("current limit did not reset the time base");

    AST_NO_EXT_RESET: assert property ( // RQ9
        !ctrl_r.extResetEn && ({1'b0, tbCount} + 17'h0_0001 < {1'b0, periodSel})
            |=> tbCount == $past(tbCount) + 16'h0001)
        else $error("time base disturbed with external reset off");

    AST_SHARED_DUTY: assert property ( // RQ6
        ctrl_r.sharedDuty && ctrl_r.immediate |=> activeDuty_r == $past(masterDuty_r))
        else $error("master duty not selected");

    AST_LOCAL_DUTY: assert property ( // RQ10
        !ctrl_r.sharedDuty && ctrl_r.immediate |=> activeDuty_r == $past(duty_r))
        else $error("local duty not applied immediately");

    AST_SYNC_HOLD: assert property ( // RQ11
        !ctrl_r.immediate && !tbBoundary |=> $stable(activeDuty_r))
        else $error("duty changed away from period boundary");

    AST_UNIMPL_ZERO: assert property ( // RQ14
        s_axi_arvalid && s_axi_arready && hits(s_axi_araddr, OFF_CONTROL)
            |=> s_axi_rdata[5:2] == 4'h0)
        else $error("control bits 5..2 read non-zero");

endmodule : pwmgc_top
`default_nettype wire

/* test/pwmgc_stage_model.sv */
// pwmgc_stage_model: high-side switch on-time counter on pwmHigh, and the current-limit comparator.
// assumes trip and clrCount come from the bench, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module pwmgc_stage_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        trip,
    input  wire logic        clrCount,
    input  wire logic        pwmHigh,
    output var  logic        currentLimit,
    output var  logic [15:0] onCount
);
    // registered comparator: a real one lags the sensed current
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            currentLimit <= 1'b0;
            onCount      <= 16'h0000;
        end else begin
            currentLimit <= trip;
            onCount      <= clrCount ? 16'h0000 : onCount + 16'(pwmHigh);
        end
    end
endmodule : pwmgc_stage_model
`default_nettype wire

/* test/test_pwm_generator_control_duty.sv */
// test_pwm_generator_control_duty: register, duty, dead-time and interrupt tests.
// assumes the stage model registers the bench trip onto currentLimit; the switch drive does not feed it.
`timescale 1ns/10ps
`default_nettype none
module test_pwm_generator_control_duty;
    import pwmgc_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] d;
        logic [31:0] e;
        logic [1:0]  r;
    } pwmgc_row_t;
    logic        clk = 1'b0, rst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0, trip = 1'b0, clrCount = 1'b0, trig = 1'b0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0000_0000, rData, v;
    logic [1:0]  bResp, rResp, rp;
    logic        awReady, wReady, bValid, arReady, rValid, cl, pwmHigh, pwmLow, irq;
    logic [15:0] onCount;
    int          fail_count = 0, checks_done = 0, m;
    pwmgc_row_t  rows [5] = '{
        '{OFF_CONTROL, 16'hFFFF, 32'h0000_0FC3, RESP_OKAY},
        '{OFF_DUTY, 16'h1234, 32'h0000_1234, RESP_OKAY},
        '{OFF_MASTER_DUTY, 16'h0020, 32'h0000_0020, RESP_OKAY},
        '{OFF_PHASE, 16'h0040, 32'h0000_0040, RESP_OKAY},
        '{8'h20, 16'h5555, 32'h0000_0000, RESP_SLVERR}};
    logic [15:0] dtOn [3] = '{16'd270, 16'd370, 16'd320};
    always #2 clk = ~clk;
    pwmgc_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .currentLimit(cl), .triggerEvent(trig), .pwmHigh(pwmHigh), .pwmLow(pwmLow), .irq(irq));
    pwmgc_stage_model stage_u (.clk(clk), .rst(rst), .trip(trip), .clrCount(clrCount),
        .pwmHigh(pwmHigh), .currentLimit(cl), .onCount(onCount));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        @(posedge clk);
        awAddr <= a;
        wData <= {16'h0000, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while ((awValid && !awReady) || (wValid && !wReady));
        while (!bValid) @(posedge clk);
        chk({30'h0, bResp}, {30'h0, r});
        bReady <= 1'b0;
        // irq follows a mask write one edge after the commit
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk); while (!arReady);
        arValid <= 1'b0;
        while (!rValid) @(posedge clk);
        v = rData;
        rp = rResp;
        rReady <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask : rc
    // settle one period, then count on-time over exactly ten 64-cycle periods
    task automatic onTime(input logic [15:0] e);
        repeat (64) @(posedge clk);
        clrCount <= 1'b1;
        @(posedge clk);
        clrCount <= 1'b0;
        repeat (641) @(posedge clk);
        chk({16'h0, onCount}, {16'h0, e});
    endtask : onTime
    task automatic pulse;
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        #200_000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc(OFF_DUTY, 32'h0000_0000);
        rc(OFF_CONTROL, 32'h0000_0000);
        rc(OFF_IRQ_MASK, 32'h0000_0003);
        $display("reset test done");
        for (m = 0; m < 5; m++) begin
            wr(rows[m].a, rows[m].d, rows[m].r);
            rc(rows[m].a, rows[m].e);
            chk({30'h0, rp}, {30'h0, rows[m].r});
        end
        $display("register table done");
        wr(OFF_CONTROL, 16'h0000, RESP_OKAY);
        wr(OFF_DUTY, 16'h0100, RESP_OKAY);
        rc(OFF_ACTIVE_DUTY, 32'h0000_0020);
        wr(OFF_CONTROL, 16'h0280, RESP_OKAY);
        repeat (70) @(posedge clk);
        rc(OFF_ACTIVE_DUTY, 32'h0000_0100);
        wr(OFF_CONTROL, 16'h0281, RESP_OKAY);
        wr(OFF_DUTY, 16'h0020, RESP_OKAY);
        rc(OFF_ACTIVE_DUTY, 32'h0000_0020);
        wr(OFF_CONTROL, 16'h0381, RESP_OKAY);
        wr(OFF_MASTER_DUTY, 16'h0010, RESP_OKAY);
        rc(OFF_ACTIVE_DUTY, 32'h0000_0010);
        $display("duty update test done");
        for (m = 0; m < 3; m++) begin
            wr(OFF_CONTROL, 16'h0201 | 16'(m << 6), RESP_OKAY);
            onTime(dtOn[m]);
        end
        trip <= 1'b1;
        wr(OFF_CONTROL, 16'h0283, RESP_OKAY);
        onTime(16'd640);
        chk({31'h0, pwmLow}, 32'h0);
        wr(OFF_CONTROL, 16'h0281, RESP_OKAY);
        onTime(16'd320);
        trip <= 1'b0;
        $display("time base test done");
        wr(OFF_CONTROL, 16'h0681, RESP_OKAY);
        pulse();
        chk({31'h0, irq}, 32'h1);
        rc(OFF_IRQ_STATUS, 32'h0000_0002);
        wr(OFF_IRQ_MASK, 16'h0001, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 16'h0003, RESP_OKAY);
        wr(OFF_IRQ_STATUS, 16'h0002, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        pulse();
        wr(OFF_CONTROL, 16'h0281, RESP_OKAY);
        rc(OFF_IRQ_STATUS, 32'h0000_0000);
        pulse();
        chk({31'h0, irq}, 32'h0);
        wr(OFF_CONTROL, 16'h0A81, RESP_OKAY);
        trip <= 1'b1;
        repeat (4) @(posedge clk);
        trip <= 1'b0;
        chk({31'h0, irq}, 32'h1);
        rc(OFF_CONTROL, 32'h0000_4A81);
        wr(OFF_CONTROL, 16'h0281, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        rc(OFF_IRQ_STATUS, 32'h0000_0000);
        $display("interrupt test done");
        print_verdict();
    end
endmodule : test_pwm_generator_control_duty
`default_nettype wire
